// *** rtl/esp_pkg.sv ***
// package for the edge sensor condition and position readout
// assumes one system clock and a classic wishbone register bus
package esp_pkg;

    // ---------------------------------------------------------------
    // widths
    // ---------------------------------------------------------------
    localparam int unsigned WB_AW       = 8;
    localparam int unsigned WB_DW       = 32;
    localparam int unsigned WORD_W      = 16;
    localparam int unsigned NUM_SENSORS = 2;
    localparam int unsigned SEQ_W       = 8;

    // ---------------------------------------------------------------
    // register indices, byte address is four times the index
    // ---------------------------------------------------------------
    localparam logic [5:0] IDX_COND1  = 6'h00;
    localparam logic [5:0] IDX_COND2  = 6'h01;
    localparam logic [5:0] IDX_LEFT1  = 6'h02;
    localparam logic [5:0] IDX_RIGHT1 = 6'h03;
    localparam logic [5:0] IDX_LEFT2  = 6'h05;
    localparam logic [5:0] IDX_RIGHT2 = 6'h06;
    localparam logic [5:0] IDX_CTRL1  = 6'h10;
    localparam logic [5:0] IDX_CTRL2  = 6'h11;
    localparam logic [5:0] IDX_SEQ    = 6'h12;

    // ---------------------------------------------------------------
    // condition word layout
    // ---------------------------------------------------------------
    localparam int unsigned BIT_NO_SENSOR = 0;
    localparam int unsigned BIT_LOW_CONTR = 1;
    localparam int unsigned BIT_NO_WEB    = 2;
    localparam int unsigned BIT_WRONG_OR  = 3;
    localparam int unsigned BIT_STATIC_TH = 4;
    localparam int unsigned BIT_FLUTTER   = 5;
    localparam int unsigned BIT_SUBPIXEL  = 6;
    localparam int unsigned BIT_FAMILY    = 7;
    localparam int unsigned BIT_LEFT_CFG  = 8;
    localparam int unsigned BIT_RIGHT_CFG = 9;
    localparam int unsigned PIX_LSB       = 10;
    localparam int unsigned PIX_MSB       = 13;
    localparam int unsigned MODE_LSB      = 14;
    localparam int unsigned MODE_MSB      = 15;

    localparam logic [1:0] MODE_EDGE     = 2'h0;
    localparam logic [1:0] MODE_CONTRAST = 2'h1;

    // no sensor and no web until the first measurement lands
    localparam logic [15:0] COND_RESET = 16'h0005;
    localparam logic [5:0]  CTRL_RESET = 6'h04;

    // ---------------------------------------------------------------
    // carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic        present;
        logic        low_contrast;
        logic        web_seen;
        logic        wrong_orient;
        logic        flutter;
        logic        family;
        logic [3:0]  pixel_code;
        logic [15:0] edge_left;
        logic [15:0] edge_right;
        logic        all_open;
        logic        all_covered;
        logic        contrast_seen;
        logic [15:0] contrast_pos;
        logic        meas_done;
    } esp_sensor_in_s;

    typedef struct packed {
        logic [1:0] mode;
        logic       right_cfg;
        logic       left_cfg;
        logic       subpixel;
        logic       static_th;
    } esp_ctrl_s;

    // ---------------------------------------------------------------
    // pixel count per family and code, unlisted codes give zero
    // ---------------------------------------------------------------
    function automatic logic [15:0] esp_pixel_count(input logic family,
                                                    input logic [3:0] code);
        logic [15:0] n;
        n = 16'h0000;
        if (!family) begin
            case (code)
                4'h0:    n = 16'd256;
                4'h1:    n = 16'd768;
                4'h2:    n = 16'd1774;
                4'h3:    n = 16'd896;
                4'h5:    n = 16'd1792;
                4'h6:    n = 16'd1772;
                4'h7:    n = 16'd3544;
                4'h8:    n = 16'd3554;
                4'hE:    n = 16'd7108;
                default: n = 16'h0000;
            endcase
        end else begin
            case (code)
                4'h1:    n = 16'd760;
                4'h2:    n = 16'd764;
                4'h3:    n = 16'd1536;
                4'h4:    n = 16'd1526;
                4'h5:    n = 16'd3052;
                4'h6:    n = 16'd2284;
                4'h8:    n = 16'd3042;
                4'hA:    n = 16'd3800;
                4'hC:    n = 16'd6074;
                4'hE:    n = 16'd7590;
                default: n = 16'h0000;
            endcase
        end
        return n;
    endfunction

endpackage

// *** rtl/esp_sensor_readout.sv ***
// edge sensor condition and position readout, read over wishbone
// assumes sensor front ends deliver results synchronous to i_sys_clk
//
// Notes on behaviour
// - low byte faults plus static, subpixel and family bits, high byte status and configuration
// - bit 0 set when no sensor attached
// - bit 1 set when contrast is low
// - bit 2 set when no web detected
// - bit 3 set on opposite orientation edge
// - bit 4 set for static thresholding
// - bit 5 set on flutter or out-of-plane movement
// - bit 6 set for fourfold subpixel resolution
// - bit 7 gives sensor family, selects pixel table
// - bits 10..13 hold pixel count code
// - bit 8 left config, bit 9 right config
// - both config bits mean center sensor mode
// - bits 14..15 sensing mode, edge or contrast
// - left word gives left edge, zero if right
// - second word: right edge or contrast position
// - no contrast seen gives pixel count
// - position grows as web moves rightward
// - open and covered ends follow orientation
// - word 0 sensor one, word 1 sensor two
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module esp_sensor_readout (
    // clock and reset
    input  wire logic                            i_sys_clk,
    input  wire logic                            i_rst_n,
    // wishbone slave
    input  wire logic                            i_wb_cyc,
    input  wire logic                            i_wb_stb,
    input  wire logic                            i_wb_we,
    input  wire logic [esp_pkg::WB_AW-1:0]       i_wb_adr,
    input  wire logic [3:0]                      i_wb_sel,
    input  wire logic [esp_pkg::WB_DW-1:0]       i_wb_dat,
    output logic                                 o_wb_ack,
    output logic      [esp_pkg::WB_DW-1:0]       o_wb_dat,
    // sensor measurement results
    input  wire esp_pkg::esp_sensor_in_s         i_sensor1,
    input  wire esp_pkg::esp_sensor_in_s         i_sensor2
);
    import esp_pkg::*;

    // ---------------------------------------------------------------
    // functions
    // ---------------------------------------------------------------
    // open and covered ends depend on which side the web enters
    function automatic logic [15:0] edge_pos(input logic [15:0] raw,
                                             input logic        open,
                                             input logic        covered,
                                             input logic        left_or,
                                             input logic [15:0] npix);
        logic [15:0] p;
        p = raw;
        if (open) begin
            p = left_or ? npix : 16'h0000;
        end else if (covered) begin
            p = left_or ? 16'h0000 : npix;
        end
        return p;
    endfunction

    function automatic logic [5:0] word_index(input logic [7:0] adr);
        return adr[7:2];
    endfunction

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    esp_sensor_in_s           sens        [NUM_SENSORS];
    esp_ctrl_s                ctrl_reg    [NUM_SENSORS];
    logic [WORD_W-1:0]        cond_reg    [NUM_SENSORS];
    logic [WORD_W-1:0]        left_reg    [NUM_SENSORS];
    logic [WORD_W-1:0]        right_reg   [NUM_SENSORS];
    logic [SEQ_W-1:0]         seq_reg     [NUM_SENSORS];
    logic [WORD_W-1:0]        cond_next   [NUM_SENSORS];
    logic [WORD_W-1:0]        left_next   [NUM_SENSORS];
    logic [WORD_W-1:0]        right_next  [NUM_SENSORS];
    logic [WORD_W-1:0]        npix        [NUM_SENSORS];
    logic                     wb_req;
    logic [5:0]               wb_idx;
    logic [WB_DW-1:0]         rd_data;
    logic                     ack_reg;
    logic [WB_DW-1:0]         dat_reg;

    assign sens[0] = i_sensor1;
    assign sens[1] = i_sensor2;

    // ---------------------------------------------------------------
    // condition and position words
    // ---------------------------------------------------------------
    always_comb begin
        for (int s = 0; s < NUM_SENSORS; s++) begin
            npix[s] = esp_pixel_count(sens[s].family, sens[s].pixel_code);
            cond_next[s] = 16'h0000;
            // fault flags plus static, subpixel and family bits in the low byte
            cond_next[s][BIT_NO_SENSOR] = ~sens[s].present;
            cond_next[s][BIT_LOW_CONTR] = sens[s].low_contrast;
            cond_next[s][BIT_NO_WEB]    = ~sens[s].web_seen;
            cond_next[s][BIT_WRONG_OR]  = sens[s].wrong_orient;
            cond_next[s][BIT_STATIC_TH] = ctrl_reg[s].static_th;
            cond_next[s][BIT_FLUTTER]   = sens[s].flutter;
            cond_next[s][BIT_SUBPIXEL]  = ctrl_reg[s].subpixel;
            cond_next[s][BIT_FAMILY]    = sens[s].family;
            // status and configuration in the high byte
            cond_next[s][BIT_LEFT_CFG]  = ctrl_reg[s].left_cfg;
            cond_next[s][BIT_RIGHT_CFG] = ctrl_reg[s].right_cfg;
            cond_next[s][PIX_MSB:PIX_LSB]   = sens[s].pixel_code;
            cond_next[s][MODE_MSB:MODE_LSB] = ctrl_reg[s].mode;

            // left word only carries meaning for left or center setup
            left_next[s] = 16'h0000;
            if (ctrl_reg[s].mode == MODE_EDGE && ctrl_reg[s].left_cfg) begin
                left_next[s] = edge_pos(sens[s].edge_left,
                                        sens[s].all_open,
                                        sens[s].all_covered,
                                        1'b1, npix[s]);
            end

            // reserved modes report zero positions
            right_next[s] = 16'h0000;
            if (ctrl_reg[s].mode == MODE_CONTRAST) begin
                right_next[s] = sens[s].contrast_seen ?
                                sens[s].contrast_pos : npix[s];
            end else if (ctrl_reg[s].mode == MODE_EDGE &&
                         ctrl_reg[s].right_cfg) begin
                // right-only takes right ends, center keeps left ends
                right_next[s] = edge_pos(sens[s].edge_right,
                                         sens[s].all_open,
                                         sens[s].all_covered,
                                         ctrl_reg[s].left_cfg,
                                         npix[s]);
            end
        end
    end

    // ---------------------------------------------------------------
    // snapshot per measurement
    // ---------------------------------------------------------------
    // all words of one sensor move in the same edge, never piecemeal
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int s = 0; s < NUM_SENSORS; s++) begin
                cond_reg[s]  <= COND_RESET;
                left_reg[s]  <= 16'h0000;
                right_reg[s] <= 16'h0000;
            end
        end else begin
            for (int s = 0; s < NUM_SENSORS; s++) begin
                if (sens[s].meas_done) begin
                    cond_reg[s]  <= cond_next[s];
                    left_reg[s]  <= left_next[s];
                    right_reg[s] <= right_next[s];
                end
            end
        end
    end

    // sequence counters let software spot a set that changed mid-read
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int s = 0; s < NUM_SENSORS; s++) begin
                seq_reg[s] <= 8'h00;
            end
        end else begin
            for (int s = 0; s < NUM_SENSORS; s++) begin
                if (sens[s].meas_done) begin
                    seq_reg[s] <= seq_reg[s] + 8'h01;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // wishbone slave
    // ---------------------------------------------------------------
    assign wb_req = i_wb_cyc & i_wb_stb & ~ack_reg;
    assign wb_idx = word_index(i_wb_adr);

    // control registers: only byte lane 0 holds bits
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int s = 0; s < NUM_SENSORS; s++) begin
                ctrl_reg[s] <= CTRL_RESET;
            end
        end else if (wb_req && i_wb_we && i_wb_sel[0]) begin
            if (wb_idx == IDX_CTRL1) begin
                ctrl_reg[0] <= i_wb_dat[5:0];
            end
            if (wb_idx == IDX_CTRL2) begin
                ctrl_reg[1] <= i_wb_dat[5:0];
            end
        end
    end

    // writes to measurement words are dropped: they are read-only
    always_comb begin
        rd_data = 32'h0000_0000;
        case (wb_idx)
            IDX_COND1:  rd_data = {16'h0000, cond_reg[0]};
            IDX_COND2:  rd_data = {16'h0000, cond_reg[1]};
            IDX_LEFT1:  rd_data = {16'h0000, left_reg[0]};
            IDX_RIGHT1: rd_data = {16'h0000, right_reg[0]};
            IDX_LEFT2:  rd_data = {16'h0000, left_reg[1]};
            IDX_RIGHT2: rd_data = {16'h0000, right_reg[1]};
            IDX_CTRL1:  rd_data = {26'h000_0000, ctrl_reg[0]};
            IDX_CTRL2:  rd_data = {26'h000_0000, ctrl_reg[1]};
            IDX_SEQ:    rd_data = {16'h0000, seq_reg[1], seq_reg[0]};
            default:    rd_data = 32'h0000_0000;
        endcase
    end

    // one wait state; unmapped addresses still ack with zero
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= wb_req;
            if (wb_req && !i_wb_we) begin
                dat_reg <= rd_data;
            end
        end
    end

    assign o_wb_ack = ack_reg;
    assign o_wb_dat = dat_reg;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    chk_no_sensor_flag: assert property (
        sens[0].meas_done |=>
            cond_reg[0][BIT_NO_SENSOR] == !$past(sens[0].present))
        else $error("no sensor flag wrong");

    chk_fault_byte: assert property (
        sens[1].meas_done |=>
            cond_reg[1][BIT_NO_WEB] == !$past(sens[1].web_seen) &&
            cond_reg[1][BIT_LOW_CONTR] == $past(sens[1].low_contrast))
        else $error("fault byte wrong");

    chk_center_cfg: assert property (
        sens[0].meas_done && ctrl_reg[0].left_cfg && ctrl_reg[0].right_cfg
        |=> cond_reg[0][BIT_LEFT_CFG] && cond_reg[0][BIT_RIGHT_CFG])
        else $error("center config bits missing");

    chk_mode_field: assert property (
        sens[0].meas_done |=>
            cond_reg[0][MODE_MSB:MODE_LSB] == $past(ctrl_reg[0].mode))
        else $error("mode field wrong");

    chk_left_zero_right: assert property (
        sens[0].meas_done && ctrl_reg[0].right_cfg && !ctrl_reg[0].left_cfg
        |=> left_reg[0] == 16'h0000)
        else $error("left word not zero for right sensor");

    chk_no_contrast_npix: assert property (
        sens[0].meas_done && ctrl_reg[0].mode == MODE_CONTRAST &&
        !sens[0].contrast_seen |=> right_reg[0] == $past(npix[0]))
        else $error("contrast word not pixel count");

    chk_left_open_end: assert property (
        sens[0].meas_done && ctrl_reg[0].mode == MODE_EDGE &&
        ctrl_reg[0].left_cfg && sens[0].all_open
        |=> left_reg[0] == $past(npix[0]))
        else $error("left orientation open end wrong");

    chk_right_cover_end: assert property (
        sens[1].meas_done && ctrl_reg[1].mode == MODE_EDGE &&
        ctrl_reg[1].right_cfg && !ctrl_reg[1].left_cfg &&
        sens[1].all_covered && !sens[1].all_open
        |=> right_reg[1] == $past(npix[1]))
        else $error("right orientation covered end wrong");

    chk_words_hold: assert property (
        !sens[0].meas_done |=> $stable(cond_reg[0]) &&
            $stable(left_reg[0]) && $stable(right_reg[0]))
        else $error("sensor words moved without measurement");

    chk_word0_read: assert property (
        wb_req && !i_wb_we && wb_idx == IDX_COND1
        |=> o_wb_ack && o_wb_dat[15:0] == $past(cond_reg[0]) ##1 !o_wb_ack)
        else $error("word 0 read wrong");

    chk_wrong_orient: assert property (
        sens[0].meas_done |=>
            cond_reg[0][BIT_WRONG_OR] == $past(sens[0].wrong_orient))
        else $error("wrong orientation flag wrong");

    chk_static_bit: assert property (
        sens[1].meas_done |=>
            cond_reg[1][BIT_STATIC_TH] == $past(ctrl_reg[1].static_th))
        else $error("static threshold bit wrong");

    chk_flutter_bit: assert property (
        sens[1].meas_done |=>
            cond_reg[1][BIT_FLUTTER] == $past(sens[1].flutter))
        else $error("flutter flag wrong");

    chk_subpixel_bit: assert property (
        sens[0].meas_done |=>
            cond_reg[0][BIT_SUBPIXEL] == $past(ctrl_reg[0].subpixel))
        else $error("subpixel bit wrong");

    chk_family_code: assert property (
        sens[1].meas_done |=>
            cond_reg[1][BIT_FAMILY] == $past(sens[1].family) &&
            cond_reg[1][PIX_MSB:PIX_LSB] == $past(sens[1].pixel_code))
        else $error("family or pixel code wrong");

    chk_orient_bits: assert property (
        sens[1].meas_done |=>
            cond_reg[1][BIT_LEFT_CFG] == $past(ctrl_reg[1].left_cfg) &&
            cond_reg[1][BIT_RIGHT_CFG] == $past(ctrl_reg[1].right_cfg))
        else $error("orientation bits wrong");

    chk_contrast_pos: assert property (
        sens[1].meas_done && ctrl_reg[1].mode == MODE_CONTRAST &&
        sens[1].contrast_seen
        |=> right_reg[1] == $past(sens[1].contrast_pos))
        else $error("contrast position wrong");

    chk_left_edge_pass: assert property (
        sens[0].meas_done && ctrl_reg[0].mode == MODE_EDGE &&
        ctrl_reg[0].left_cfg && !sens[0].all_open && !sens[0].all_covered
        |=> left_reg[0] == $past(sens[0].edge_left))
        else $error("left edge position wrong");

    chk_right_open_end: assert property (
        sens[0].meas_done && ctrl_reg[0].mode == MODE_EDGE &&
        ctrl_reg[0].right_cfg && !ctrl_reg[0].left_cfg && sens[0].all_open
        |=> right_reg[0] == 16'h0000)
        else $error("right orientation open end wrong");

    chk_center_open_end: assert property (
        sens[0].meas_done && ctrl_reg[0].mode == MODE_EDGE &&
        ctrl_reg[0].left_cfg && ctrl_reg[0].right_cfg && sens[0].all_open
        |=> right_reg[0] == $past(npix[0]))
        else $error("center open end wrong");

    chk_hold_sensor2: assert property (
        !sens[1].meas_done |=> $stable(cond_reg[1]) &&
            $stable(left_reg[1]) && $stable(right_reg[1]))
        else $error("sensor two words moved without measurement");

    chk_word1_read: assert property (
        wb_req && !i_wb_we && wb_idx == IDX_COND2
        |=> o_wb_ack && o_wb_dat[15:0] == $past(cond_reg[1]) ##1 !o_wb_ack)
        else $error("word 1 read wrong");

endmodule

`default_nettype wire

// *** verification/esp_sensor_model.sv ***
// sensor front-end stand-in that presents one measurement per request
// assumes the bench raises i_go just after a rising edge of i_sys_clk
`timescale 1ns/100ps
`default_nettype none

module esp_sensor_model (
    // clock and reset
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_rst_n,
    // request from the bench
    input  wire logic                   i_go,
    input  wire esp_pkg::esp_sensor_in_s i_meas,
    // toward the readout
    output var esp_pkg::esp_sensor_in_s  o_meas
);
    import esp_pkg::*;

    logic [31:0] junk_reg;

    // fields mean nothing outside the strobe, so they never hold still
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            junk_reg <= 32'hA5A5_0F0F;
        end else begin
            junk_reg <= {junk_reg[30:0], junk_reg[31] ^ junk_reg[21]};
        end
    end

    always_comb begin
        o_meas = {junk_reg, ~junk_reg[29:1], 1'b0};
        if (i_go) begin
            o_meas = i_meas;
            o_meas.meas_done = 1'b1;
        end
    end
endmodule

`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench for the sensor condition and position readout
// assumes a wishbone master here and two sensor stand-in models
`timescale 1ns/100ps
`default_nettype none

module tb;
    import esp_pkg::*;

    logic                 clk, rst_n, cyc, stb, we, ack;
    logic [7:0]           adr;
    logic [3:0]           sel;
    logic [31:0]          wdat, rdat, q;
    logic [1:0]           go;
    esp_sensor_in_s       req [2];
    esp_sensor_in_s       s1, s2;
    logic [5:0]           ctrl [2];
    logic [7:0]           seq [2];
    integer               fail_count, num_checks, seed, i, k;
    // family, code, pixel count; last two codes are unlisted
    localparam logic [20:0] PIX [6] = '{
        {5'h00, 16'd256}, {5'h0E, 16'd7108}, {5'h11, 16'd760},
        {5'h1E, 16'd7590}, {5'h04, 16'd0}, {5'h10, 16'd0}};

    esp_sensor_readout u_dut (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_ack(ack), .o_wb_dat(rdat), .i_sensor1(s1), .i_sensor2(s2));
    esp_sensor_model u_m1 (.i_sys_clk(clk), .i_rst_n(rst_n),
        .i_go(go[0]), .i_meas(req[0]), .o_meas(s1));
    esp_sensor_model u_m2 (.i_sys_clk(clk), .i_rst_n(rst_n),
        .i_go(go[1]), .i_meas(req[1]), .o_meas(s2));

    // ----------------------------------------------------------------
    // expectations
    // ----------------------------------------------------------------
    function automatic logic [15:0] npix(input esp_sensor_in_s m);
        npix = 16'h0000;
        for (int j = 0; j < 6; j++) begin
            if (PIX[j][20:16] == {m.family, m.pixel_code}) npix = PIX[j][15:0];
        end
    endfunction

    function automatic logic [15:0] exp_cond(input esp_sensor_in_s m,
                                             input logic [5:0] c);
        return {c[5:4], m.pixel_code, c[3], c[2], m.family, c[1],
                m.flutter, c[0], m.wrong_orient, ~m.web_seen,
                m.low_contrast, ~m.present};
    endfunction

    function automatic logic [15:0] exp_left(input esp_sensor_in_s m,
                                             input logic [5:0] c);
        if (c[5:4] != MODE_EDGE || !c[2]) return 16'h0000;
        if (m.all_open) return npix(m);
        if (m.all_covered) return 16'h0000;
        return m.edge_left;
    endfunction

    function automatic logic [15:0] exp_right(input esp_sensor_in_s m,
                                              input logic [5:0] c);
        if (c[5:4] == MODE_CONTRAST) begin
            return m.contrast_seen ? m.contrast_pos : npix(m);
        end
        if (c[5:4] != MODE_EDGE || !c[3]) return 16'h0000;
        // center mode keeps the left-orientation ends
        if (m.all_open) return c[2] ? npix(m) : 16'h0000;
        if (m.all_covered) return c[2] ? 16'h0000 : npix(m);
        return m.edge_right;
    endfunction

    // ----------------------------------------------------------------
    // bus and reporting tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (fail_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
        @(posedge clk);
        // no local limit: only the watchdog ends a hung wait
        while (ack !== 1'b1) begin
            @(posedge clk);
        end
        q = rdat;
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0000_0000, 4'hF);
        check(q, exp);
    endtask

    task automatic one_round(input logic twice);
        logic [63:0]    r;
        esp_sensor_in_s m;
        integer         p, j;
        for (k = 0; k < 2; k++) begin
            ctrl[k] = 6'($random(seed));
            wb(1'b1, k ? 8'h44 : 8'h40, {26'h0, ctrl[k]}, 4'h1);
        end
        // back-to-back strobes: only the last set should remain
        for (p = 0; p <= twice; p++) begin
            for (j = 0; j < 2; j++) begin
                r = {$random(seed), $random(seed)};
                m = r[61:0];
                {m.family, m.pixel_code} = PIX[$unsigned($random(seed)) % 6][20:16];
                req[j] <= m;
                seq[j] = seq[j] + 8'h01;
            end
            go <= 2'b11;
            @(posedge clk);
        end
        go <= 2'b00;
        rd(8'h40, {26'h0, ctrl[0]});
        rd(8'h44, {26'h0, ctrl[1]});
        for (k = 0; k < 2; k++) begin
            rd(k ? 8'h04 : 8'h00, {16'h0, exp_cond(req[k], ctrl[k])});
            rd(k ? 8'h14 : 8'h08, {16'h0, exp_left(req[k], ctrl[k])});
            rd(k ? 8'h18 : 8'h0C, {16'h0, exp_right(req[k], ctrl[k])});
        end
        rd(8'h48, {16'h0, seq[1], seq[0]});
    endtask

    // ----------------------------------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        #(4 * 60000);
        fail_count = fail_count + 1;
        close_out();
    end

    initial begin
        seed = 81;
        fail_count = 0;
        num_checks = 0;
        rst_n = 1'b0;
        {cyc, stb, we, adr, wdat, sel} = '0;
        go = 2'b00;
        req[0] = '0;
        req[1] = '0;
        seq[0] = 8'h00;
        seq[1] = 8'h00;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 64; i++) begin
            rd(8'(i * 4), (i < 2) ? 32'h0000_0005 : (i == 16 || i == 17) ? 32'h0000_0004 : 32'h0000_0000);
        end
        wb(1'b1, 8'h00, 32'h0000_FFFF, 4'hF);
        rd(8'h00, 32'h0000_0005);
        wb(1'b1, 8'h40, 32'h0000_003F, 4'hE);
        rd(8'h40, 32'h0000_0004);
        for (i = 0; i < 200; i++) begin
            one_round(i[0]);
        end
        close_out();
    end
endmodule

`default_nettype wire
